/* File: hdl/decoder_cfg.svh */
// Purpose: constants of the twelve-bit instruction decoder
// Assumes: one CLK period per oscillator period
// Notes: offsets are APB byte addresses
`ifndef DECODER_CFG_SVH
`define DECODER_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_INSTR 8'h00
`define OFS_ACC 8'h04
`define OFS_STATUS 8'h08
`define OFS_OPTION 8'h0C
`define OFS_PC 8'h10

// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_BUSY 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_OPTION 8'hFF
`define RST_PD 1'b1
`define RST_TO 1'b1

// ---------------------------------------------------------------
// timing and special file addresses
// ---------------------------------------------------------------
`define ICYC_CLKS 4
`define F_TICK 5'h01
`define F_PCL 5'h02
`define F_PORT0 5'h05
`define F_PORT2 5'h07
`define MISC_OPTION 5'h02
`define MISC_SLEEP 5'h03
`define MISC_KICK 5'h04

`endif

/* File: hdl/decoder_pkg.sv */
// Purpose: types of the twelve-bit instruction decoder
// Assumes: constants come from decoder_cfg.svh
// Notes: opcode fields as enums
`include "decoder_cfg.svh"
package decoder_pkg;

  // ---------------------------------------------------------------
  // execution states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_EXEC = 4'h4,
    ST_HOLD = 4'h8
  } exec_state_t;

  // byte-oriented operation, opcode bits 9:6 with 11:10 zero
  typedef enum logic [3:0] {
    B_MISC = 4'h0, B_CLR = 4'h1, B_SUB = 4'h2, B_DEC = 4'h3,
    B_OR = 4'h4, B_AND = 4'h5, B_XOR = 4'h6, B_ADD = 4'h7,
    B_MOV = 4'h8, B_COM = 4'h9, B_INC = 4'hA, B_DECSZ = 4'hB,
    B_RRC = 4'hC, B_RLC = 4'hD, B_SWAP = 4'hE, B_INCSZ = 4'hF
  } byte_op_t;

  // literal and control operation, opcode bits 11:8
  typedef enum logic [3:0] {
    L_RET = 4'h8, L_CALL = 4'h9, L_JMP0 = 4'hA, L_JMP1 = 4'hB,
    L_MOV = 4'hC, L_OR = 4'hD, L_AND = 4'hE, L_XOR = 4'hF
  } lit_op_t;

  // whole state of the decoder
  typedef struct packed {
    exec_state_t st;
    logic [2:0] cnt;
    logic two;
    logic [11:0] ir;
    logic [7:0] acc;
    logic c, dc, z, to, pd;
    logic [7:0] opt;
    logic [23:0] lat, oe, sync1, sync2;
    logic [8:0] pcv;
    logic pc_we, nine0, push, pop, wdt, slp, optld, psc, skip;
    logic mwe;
    logic [4:0] mwa;
    logic [7:0] mwd;
    logic pready, pslverr;
    logic [31:0] prdata;
  } core_t;

endpackage

/* File: hdl/file_ram.sv */
// Purpose: 32 x 8 file register store
// Assumes: one write port, one read port, same clock
// Notes: read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module file_ram (
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);
  // storage array
  logic [7:0] mem [32];

  // write then registered read
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: hdl/instr_decoder.sv */
// Purpose: decode and execute one 12-bit instruction word
// Assumes: APB master on CLK; pins arrive asynchronously
// Notes: an instruction spans four or eight CLK periods
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_cfg.svh"
module instr_decoder
  import decoder_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [23:0] PIN_IN,
  output logic [23:0] PIN_OUT,
  output logic [23:0] PIN_OE,
  input wire logic PRESCALER_ON_TIMER,
  output logic PRESCALER_CLEAR,
  output logic PC_WRITE,
  output logic [8:0] PC_VALUE,
  output logic PC_NINTH_ZERO,
  output logic STACK_PUSH,
  output logic STACK_POP,
  output logic WDT_CLEAR,
  output logic SLEEP_REQ,
  output logic OPTION_LOAD,
  output logic [7:0] OPTION_VALUE,
  output logic SKIP_NEXT
);

  // ---------------------------------------------------------------
  // state and working signals
  // ---------------------------------------------------------------
  core_t s_reg, s_next;
  logic [7:0] rdata; // file store read data
  logic [7:0] opnd; // operand from file or pins
  logic [7:0] res; // operation result
  logic [8:0] sum; // byte sum with carry out
  logic [4:0] nib; // nibble sum with half carry
  logic byte_op, wf, ww, uz, uc, udc, cval, skp;
  logic acc_ok, take;
  logic [4:0] fa; // file select
  logic [2:0] last; // final count of the instruction
  byte_op_t bop;
  lit_op_t lop;

  // file register store
  file_ram u_ram (
    .clk(CLK),
    .we(s_reg.mwe),
    .waddr(s_reg.mwa),
    .wdata(s_reg.mwd),
    .raddr(s_reg.ir[4:0]),
    .rdata(rdata)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    res = 8'h00;
    sum = 9'h000;
    nib = 5'h00;
    byte_op = 1'b0;
    wf = 1'b0;
    ww = 1'b0;
    uz = 1'b0;
    uc = 1'b0;
    udc = 1'b0;
    cval = 1'b0;
    skp = 1'b0;
    fa = s_reg.ir[4:0];
    bop = byte_op_t'(s_reg.ir[9:6]);
    lop = lit_op_t'(s_reg.ir[11:8]);
    last = s_reg.two ? 3'(2 * `ICYC_CLKS - 1) : 3'(`ICYC_CLKS - 1);
    // pulses last one cycle
    s_next.pc_we = 1'b0;
    s_next.nine0 = 1'b0;
    s_next.push = 1'b0;
    s_next.pop = 1'b0;
    s_next.wdt = 1'b0;
    s_next.slp = 1'b0;
    s_next.optld = 1'b0;
    s_next.psc = 1'b0;
    s_next.skip = 1'b0;
    s_next.mwe = 1'b0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    // two-flop pin synchroniser
    s_next.sync1 = PIN_IN;
    s_next.sync2 = s_reg.sync1;
    // operand: ports read their pins
    opnd = rdata;
    for (int i = 0; i < 3; i++)
    begin
      if (fa == 5'(`F_PORT0 + i))
      begin
        opnd = s_reg.sync2[8 * i +: 8];
      end
    end

    // APB: writes stall while an instruction runs
    acc_ok = !(PWRITE && s_reg.st != ST_IDLE);
    if (PSEL && PENABLE && !s_reg.pready && acc_ok)
    begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (PADDR)
        `OFS_INSTR: s_next.prdata = {20'h00000, s_reg.ir};
        `OFS_ACC: s_next.prdata = {24'h000000, s_reg.acc};
        `OFS_STATUS:
        begin
          s_next.prdata[`ST_C] = s_reg.c;
          s_next.prdata[`ST_DC] = s_reg.dc;
          s_next.prdata[`ST_Z] = s_reg.z;
          s_next.prdata[`ST_PD] = s_reg.pd;
          s_next.prdata[`ST_TO] = s_reg.to;
          s_next.prdata[`ST_BUSY] = s_reg.st != ST_IDLE;
        end
        `OFS_OPTION: s_next.prdata = {24'h000000, s_reg.opt};
        `OFS_PC: s_next.prdata = {23'h000000, s_reg.pcv};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    take = PSEL && PENABLE && s_reg.pready && PWRITE && !s_reg.pslverr;
    if (take)
    begin
      unique case (PADDR)
        `OFS_ACC: s_next.acc = PWDATA[7:0];
        `OFS_STATUS:
        begin
          s_next.c = PWDATA[`ST_C];
          s_next.dc = PWDATA[`ST_DC];
          s_next.z = PWDATA[`ST_Z];
        end
        default:
        begin
        end
      endcase
    end

    // execution sequence
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (take && PADDR == `OFS_INSTR)
        begin
          s_next.ir = PWDATA[11:0];
          s_next.st = ST_FETCH;
          s_next.cnt = 3'h0;
          s_next.two = 1'b0;
        end
      end
      ST_FETCH:
      begin
        // file store read is in flight
        s_next.st = ST_EXEC;
        s_next.cnt = s_reg.cnt + 3'h1;
      end
      ST_EXEC:
      begin
        s_next.st = ST_HOLD;
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.ir[11:10] == 2'b00)
        begin
          byte_op = 1'b1;
          unique case (bop)
            B_MISC:
            begin
              byte_op = 1'b0;
              if (s_reg.ir[5])
              begin
                res = s_reg.acc;
                wf = 1'b1;
              end
              else if (fa == `MISC_OPTION)
              begin
                s_next.opt = s_reg.acc;
                s_next.optld = 1'b1;
              end
              else if (fa == `MISC_SLEEP)
              begin
                s_next.pd = 1'b0;
                s_next.to = 1'b1;
                s_next.slp = 1'b1;
              end
              else if (fa == `MISC_KICK)
              begin
                s_next.pd = 1'b1;
                s_next.to = 1'b1;
                s_next.wdt = 1'b1;
              end
              else if (fa >= `F_PORT0 && fa <= `F_PORT2)
              begin
                for (int i = 0; i < 3; i++)
                begin
                  if (fa == 5'(`F_PORT0 + i))
                  begin
                    s_next.oe[8 * i +: 8] = ~s_reg.acc;
                  end
                end
              end
            end
            B_CLR:
            begin
              byte_op = 1'b0;
              uz = 1'b1;
              wf = s_reg.ir[5];
              ww = !s_reg.ir[5] && fa == 5'h00;
            end
            B_SUB, B_ADD:
            begin
              if (bop == B_SUB)
              begin
                sum = {1'b0, opnd} + {1'b0, ~s_reg.acc} + 9'h001;
                nib = {1'b0, opnd[3:0]} + {1'b0, ~s_reg.acc[3:0]} + 5'h01;
              end
              else
              begin
                sum = {1'b0, opnd} + {1'b0, s_reg.acc};
                nib = {1'b0, opnd[3:0]} + {1'b0, s_reg.acc[3:0]};
              end
              res = sum[7:0];
              cval = sum[8];
              uc = 1'b1;
              udc = 1'b1;
              uz = 1'b1;
            end
            B_DEC, B_DECSZ:
            begin
              res = opnd - 8'h01;
              uz = bop == B_DEC;
              skp = bop == B_DECSZ && res == 8'h00;
            end
            B_INC, B_INCSZ:
            begin
              res = opnd + 8'h01;
              uz = bop == B_INC;
              skp = bop == B_INCSZ && res == 8'h00;
            end
            B_OR, B_AND, B_XOR:
            begin
              res = bop == B_OR ? opnd | s_reg.acc :
                    bop == B_AND ? opnd & s_reg.acc : opnd ^ s_reg.acc;
              uz = 1'b1;
            end
            B_MOV:
            begin
              res = opnd;
              uz = 1'b1;
            end
            B_COM:
            begin
              res = ~opnd;
              uz = 1'b1;
            end
            B_RRC:
            begin
              res = {s_reg.c, opnd[7:1]};
              cval = opnd[0];
              uc = 1'b1;
            end
            B_RLC:
            begin
              res = {opnd[6:0], s_reg.c};
              cval = opnd[7];
              uc = 1'b1;
            end
            B_SWAP: res = {opnd[3:0], opnd[7:4]};
          endcase
          if (byte_op)
          begin
            wf = s_reg.ir[5];
            ww = !s_reg.ir[5];
          end
        end
        else if (s_reg.ir[11:10] == 2'b01)
        begin
          // bit operations, bit select in 7:5
          unique case (s_reg.ir[9:8])
            2'b00: res = opnd & ~(8'h01 << s_reg.ir[7:5]);
            2'b01: res = opnd | (8'h01 << s_reg.ir[7:5]);
            2'b10: skp = !opnd[s_reg.ir[7:5]];
            2'b11: skp = opnd[s_reg.ir[7:5]];
          endcase
          wf = !s_reg.ir[9];
        end
        else
        begin
          res = s_reg.ir[7:0];
          unique case (lop)
            L_RET:
            begin
              ww = 1'b1;
              s_next.pop = 1'b1;
              s_next.nine0 = 1'b1;
              s_next.two = 1'b1;
            end
            L_CALL:
            begin
              s_next.pcv = {1'b0, s_reg.ir[7:0]};
              s_next.pc_we = 1'b1;
              s_next.push = 1'b1;
              s_next.nine0 = 1'b1;
              s_next.two = 1'b1;
            end
            L_JMP0, L_JMP1:
            begin
              s_next.pcv = s_reg.ir[8:0];
              s_next.pc_we = 1'b1;
              s_next.two = 1'b1;
            end
            L_MOV: ww = 1'b1;
            L_OR, L_AND, L_XOR:
            begin
              res = lop == L_OR ? res | s_reg.acc :
                    lop == L_AND ? res & s_reg.acc : res ^ s_reg.acc;
              ww = 1'b1;
              uz = 1'b1;
            end
            default:
            begin
            end
          endcase
        end
        // write back and side effects of the file write
        if (wf)
        begin
          s_next.mwe = 1'b1;
          s_next.mwa = fa;
          s_next.mwd = res;
          s_next.psc = fa == `F_TICK && PRESCALER_ON_TIMER;
          if (fa == `F_PCL)
          begin
            s_next.pcv = {1'b0, res};
            s_next.pc_we = 1'b1;
            s_next.nine0 = 1'b1;
            s_next.two = 1'b1;
          end
          for (int i = 0; i < 3; i++)
          begin
            if (fa == 5'(`F_PORT0 + i))
            begin
              s_next.lat[8 * i +: 8] = res;
            end
          end
        end
        if (ww)
        begin
          s_next.acc = res;
        end
        if (uz)
        begin
          s_next.z = res == 8'h00;
        end
        if (uc)
        begin
          s_next.c = cval;
        end
        if (udc)
        begin
          s_next.dc = nib[4];
        end
        if (skp)
        begin
          s_next.skip = 1'b1;
          s_next.two = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // finish after four or eight oscillator periods
        if (s_reg.cnt == last)
        begin
          s_next.st = ST_IDLE;
        end
        else
        begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.to <= `RST_TO;
      s_reg.pd <= `RST_PD;
      s_reg.opt <= `RST_OPTION;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign PIN_OUT = s_reg.lat;
  assign PIN_OE = s_reg.oe;
  assign PRESCALER_CLEAR = s_reg.psc;
  assign PC_WRITE = s_reg.pc_we;
  assign PC_VALUE = s_reg.pcv;
  assign PC_NINTH_ZERO = s_reg.nine0;
  assign STACK_PUSH = s_reg.push;
  assign STACK_POP = s_reg.pop;
  assign WDT_CLEAR = s_reg.wdt;
  assign SLEEP_REQ = s_reg.slp;
  assign OPTION_LOAD = s_reg.optld;
  assign OPTION_VALUE = s_reg.opt;
  assign SKIP_NEXT = s_reg.skip;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_len;
    @(posedge CLK) disable iff (RESET)
      s_reg.st == ST_HOLD && s_next.st == ST_IDLE |->
        s_reg.cnt == (s_reg.two ? 3'h7 : 3'h3);
  endproperty
  a_len: assert property (p_len) else $error("bad cycle length");
  property p_ninth;
    @(posedge CLK) disable iff (RESET)
      PC_WRITE && PC_NINTH_ZERO |-> !PC_VALUE[8];
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit set");
  property p_psc;
    @(posedge CLK) disable iff (RESET)
      PRESCALER_CLEAR |-> $past(PRESCALER_ON_TIMER) && s_reg.mwa == 5'h01;
  endproperty
  a_psc: assert property (p_psc) else $error("stray clear");
  property p_oe;
    @(posedge CLK) disable iff (RESET)
      $changed(PIN_OE) |-> $past(s_reg.st) == ST_EXEC &&
        $past(s_reg.ir[11:5]) == 7'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("oe moved");
  property p_skip;
    @(posedge CLK) disable iff (RESET)
      SKIP_NEXT |-> s_reg.two ##[1:7] s_reg.st == ST_IDLE;
  endproperty
  a_skip: assert property (p_skip) else $error("skip length");
  property p_sleep;
    @(posedge CLK) disable iff (RESET)
      SLEEP_REQ |-> !s_reg.pd && s_reg.to;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags");
  property p_ret;
    @(posedge CLK) disable iff (RESET)
      STACK_POP |-> s_reg.acc == s_reg.ir[7:0] && s_reg.two;
  endproperty
  a_ret: assert property (p_ret) else $error("return value");
  property p_movl;
    @(posedge CLK) disable iff (RESET)
      s_reg.st == ST_EXEC && s_reg.ir[11:8] == 4'hC |=> $stable(s_reg.z);
  endproperty
  a_movl: assert property (p_movl) else $error("flag changed");
  c_skip: cover property (@(posedge CLK) SKIP_NEXT);
  c_jump: cover property (@(posedge CLK) PC_WRITE && !PC_NINTH_ZERO);
  c_dir: cover property (@(posedge CLK) $changed(PIN_OE));
  c_sleep: cover property (@(posedge CLK) SLEEP_REQ);
endmodule
`default_nettype wire

/* File: tb/twelve_bit_instruction_decoder_test.sv */
// Purpose: self-checking bench of the instruction decoder
// Assumes: APB master on CLK; registers at the cfg offsets
// Notes: cycle counts measured as extra cycles over a no-op
`timescale 1ns/1ps
`default_nettype none
`include "decoder_cfg.svh"
module twelve_bit_instruction_decoder_test
  import decoder_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PRESCALER_ON_TIMER;
  logic [7:0] PADDR, OPTION_VALUE;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, PC_WRITE, PC_NINTH_ZERO, STACK_PUSH;
  logic STACK_POP, WDT_CLEAR, SLEEP_REQ, OPTION_LOAD, SKIP_NEXT;
  logic PRESCALER_CLEAR;
  logic [23:0] PIN_IN, PIN_OUT, PIN_OE;
  logic [8:0] PC_VALUE, pulses;
  int cnt[9], snap[9]; // pulse counters and a snapshot
  int cyc, n_errors, total_checks, n, base;
  logic [31:0] rd; // last read data
  logic er; // last error response
  logic [51:0] a;
  logic [71:0] p;
  // alu rows: instr, w, f, flags in, w out, f out, flags out
  localparam logic [51:0] ATAB [25] = '{
    52'h1C8_17_C2_0_D9_C2_0, 52'h1E8_0F_F1_0_0F_00_7,
    52'h088_06_05_7_FF_05_0, 52'h0A8_10_10_0_10_00_7,
    52'h0E8_33_01_3_33_00_7, 52'h288_55_FF_0_00_FF_4,
    52'h268_11_5A_4_11_A5_0, 52'h208_44_00_3_00_00_7,
    52'h3A8_22_3C_5_22_C3_5, 52'h108_0F_F0_7_FF_F0_3,
    52'h168_17_C2_4_17_02_0, 52'h188_5A_5A_3_00_5A_7,
    52'h348_99_81_4_02_81_5, 52'h328_66_02_3_66_81_2,
    52'h068_12_77_0_12_00_4, 52'h040_66_99_0_00_99_4,
    52'h028_AB_00_6_AB_AB_6, 52'h2E8_33_02_7_33_01_7,
    52'hC5A_77_10_4_5A_10_4, 52'hD00_00_10_0_00_10_4,
    52'hE5F_A3_10_4_03_10_0, 52'hFFF_FF_10_0_00_10_4,
    52'h4E8_01_C7_7_01_47_7, 52'h508_01_00_0_01_01_0,
    52'h8A5_01_10_5_A5_10_5};
  // control rows: instr, f, prescaler on, extra, pulses, mask, pc, status
  localparam logic [71:0] PTAB [18] = '{
    72'h2E8_01_0_4_010_1F6_FFF_FF, 72'h2E8_02_0_0_000_1F6_FFF_FF,
    72'h3E8_FF_0_4_010_1F6_FFF_FF, 72'h608_00_0_4_010_1F6_FFF_FF,
    72'h608_01_0_0_000_1F6_FFF_FF, 72'h708_01_0_4_010_1F6_FFF_FF,
    72'h708_00_0_0_000_1F6_FFF_FF, 72'hB23_00_0_4_001_1FF_123_FF,
    72'h945_00_0_4_00B_1FF_045_FF, 72'h8A5_00_0_4_00C_1FE_FFF_FF,
    72'h022_77_0_4_009_1FF_077_FF, 72'h003_00_0_0_040_1FF_FFF_10,
    72'h004_00_0_0_020_1FF_FFF_18, 72'h002_3C_0_0_080_1FF_FFF_FF,
    72'h021_00_1_0_100_1FF_FFF_FF, 72'h2A1_00_1_0_100_1FF_FFF_FF,
    72'h281_00_1_0_000_1FF_FFF_FF, 72'h021_00_0_0_000_1FF_FFF_FF};

  assign pulses = {PRESCALER_CLEAR, OPTION_LOAD, SLEEP_REQ, WDT_CLEAR,
    SKIP_NEXT, PC_NINTH_ZERO, STACK_POP, STACK_PUSH, PC_WRITE};

  instr_decoder dut_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PRESCALER_ON_TIMER(PRESCALER_ON_TIMER),
    .PRESCALER_CLEAR(PRESCALER_CLEAR), .PC_WRITE(PC_WRITE),
    .PC_VALUE(PC_VALUE), .PC_NINTH_ZERO(PC_NINTH_ZERO),
    .STACK_PUSH(STACK_PUSH), .STACK_POP(STACK_POP),
    .WDT_CLEAR(WDT_CLEAR), .SLEEP_REQ(SLEEP_REQ),
    .OPTION_LOAD(OPTION_LOAD), .OPTION_VALUE(OPTION_VALUE),
    .SKIP_NEXT(SKIP_NEXT));

  // ---------------------------------------------------------------
  // clock, cycle count and pulse counters
  // ---------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 9; i++)
      if (pulses[i] === 1'b1)
        cnt[i] <= cnt[i] + 1;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compare and count
  task automatic check(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high or 200 cycles pass
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    int k;
    k = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 200);
    if (k >= 200)
      n_errors++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  // poll the busy bit, bounded
  task automatic wait_idle();
    rd = 32'h20;
    for (int i = 0; i < 60 && rd[`ST_BUSY] !== 1'b0; i++)
      apb(1'b0, `OFS_STATUS, 32'h0);
    // a decoder that never goes idle counts as a mismatch
    if (rd[`ST_BUSY] !== 1'b0)
      n_errors++;
  endtask

  task automatic exec(input logic [11:0] ins);
    apb(1'b1, `OFS_INSTR, {20'h0, ins});
    wait_idle();
  endtask

  // place v in file 8, leaving v in the accumulator
  task automatic setf(input logic [7:0] v);
    apb(1'b1, `OFS_ACC, {24'h0, v});
    exec(12'h028);
  endtask

  // span from one instruction to a stalled no-op behind it
  task automatic timed(input logic [11:0] ins, output int t);
    int t0;
    apb(1'b1, `OFS_INSTR, {20'h0, ins});
    t0 = cyc;
    apb(1'b1, `OFS_INSTR, 32'h0);
    t = cyc - t0;
    wait_idle();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog against a hang
  // ---------------------------------------------------------------
  initial
  begin
    repeat (60000) @(posedge CLK);
    n_errors++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    PRESCALER_ON_TIMER = 1'b0;
    PIN_IN = 24'h00000F; // upper pins of port 0 held low outside
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    // reset values and unmapped access
    check("oe", PIN_OE, 24'h0);
    check("option", OPTION_VALUE, 8'hFF);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd, 32'h18);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h40, 32'h5);
    check("unmapped wr", er, 1'b1);
    $display("test reset done");
    // arithmetic, logic and literal table
    for (int i = 0; i < 25; i++)
    begin
      a = ATAB[i];
      setf(a[31:24]);
      apb(1'b1, `OFS_ACC, {24'h0, a[39:32]});
      apb(1'b1, `OFS_STATUS, {29'h0, a[22:20]});
      exec(a[51:40]);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check("flags", rd & 32'h7, {28'h0, a[3:0]});
      apb(1'b0, `OFS_ACC, 32'h0);
      check("acc", rd, {24'h0, a[19:12]});
      exec(12'h208);
      apb(1'b0, `OFS_ACC, 32'h0);
      check("file", rd, {24'h0, a[11:4]});
    end
    $display("test alu done");
    // cycle counts and side-effect pulses
    timed(12'h000, base);
    for (int i = 0; i < 18; i++)
    begin
      p = PTAB[i];
      PRESCALER_ON_TIMER <= p[48];
      setf(p[59:52]);
      snap = cnt;
      timed(p[71:60], n);
      check("cycles", n - base, {28'h0, p[47:44]});
      for (int b = 0; b < 9; b++)
        if (p[20 + b])
          check("pulse", cnt[b] - snap[b], p[32 + b]);
      if (p[19:8] != 12'hFFF)
      begin
        apb(1'b0, `OFS_PC, 32'h0);
        check("pc", rd, {20'h0, p[19:8]});
        check("pc out", PC_VALUE, {23'h0, p[16:8]});
      end
      if (p[7:0] != 8'hFF)
      begin
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("wake", rd & 32'h18, {24'h0, p[7:0]});
      end
    end
    check("option", OPTION_VALUE, 8'h3C);
    apb(1'b0, `OFS_OPTION, 32'h0);
    check("option rd", rd, 32'h3C);
    $display("test control done");
    // direction latches and port self-modify
    setf(8'h0F);
    exec(12'h005);
    check("oe0", PIN_OE[7:0], 8'hF0);
    setf(8'hAA);
    exec(12'h007);
    check("oe2", PIN_OE[23:16], 8'h55);
    setf(8'hFF);
    exec(12'h006);
    check("oe1", PIN_OE[15:8], 8'h00);
    exec(12'h025);
    check("latch", PIN_OUT[7:0], 8'hFF);
    exec(12'h225);
    check("rmw", PIN_OUT[7:0], 8'h0F);
    apb(1'b0, `OFS_INSTR, 32'h0);
    check("instr rd", rd, 32'h225);
    $display("test ports done");
    summarize();
  end
endmodule
`default_nettype wire
